// [hw/bju_defines.svh]
`ifndef BJU_DEFINES_SVH
`define BJU_DEFINES_SVH

// Instruction geometry: 64-bit bundles, byte addressed
`define BJU_INSN_BYTES      32'h0000_0008
`define BJU_INSN_SHIFT      3
`define BJU_ALIGN_MASK      32'hFFFF_FFF8
`define BJU_BACK_BIAS       32'hF000_0000
`define BJU_LINK_REG        6'h37
`define BJU_ZERO_REG        6'h3F

// Slot decode of the x_pipe_slot_one opcode field
`define BJU_SLOT_ONE        2'h1
`define BJU_OPC_JUMP_BACK   4'hA
`define BJU_OPC_JUMP_FWD    4'hB
`define BJU_OPC_BRANCH      4'h5
`define BJU_OPC_INDIRECT    4'h0

// Field positions inside the bundle
`define BJU_OPC_HI          62
`define BJU_OPC_LO          59
`define BJU_JUMP_OFFSET_FIELD_HI         58
`define BJU_JUMP_OFFSET_FIELD_LO         31
`define BJU_BOFF_HI         47
`define BJU_BOFF_LO         31
`define BJU_SUB_HI          51
`define BJU_SUB_LO          48
`define BJU_SRC_HI          42
`define BJU_SRC_LO          37
`define BJU_DST_HI          36
`define BJU_DST_LO          31

// Branch sub-ops
`define BJU_SUB_BLZ         4'h0
`define BJU_SUB_BLZT        4'h1
`define BJU_SUB_BNZ         4'h2
`define BJU_SUB_BNZT        4'h3
`define BJU_SUB_BZ          4'h4
`define BJU_SUB_BZT         4'h5
// Indirect sub-ops
`define BJU_SUB_JALR        4'h0
`define BJU_SUB_JALRP       4'h1
`define BJU_SUB_JR          4'h2
`define BJU_SUB_JRP         4'h3
`define BJU_SUB_LNK         4'h4
`define BJU_SUB_JALB        4'h5
`define BJU_SUB_JALF        4'h6

// Return stack
`define BJU_RAS_DEPTH       8
`define BJU_RAS_PTR_W       3

`endif

// [hw/bju_pkg.sv]
package bju_pkg;
  typedef enum logic [3:0] {
    BJU_OP_NONE  = 4'h0,
    BJU_OP_BLZ   = 4'h1,
    BJU_OP_BLZT  = 4'h2,
    BJU_OP_BNZ   = 4'h3,
    BJU_OP_BNZT  = 4'h4,
    BJU_OP_BZ    = 4'h5,
    BJU_OP_BZT   = 4'h6,
    BJU_OP_JB    = 4'h7,
    BJU_OP_JF    = 4'h8,
    BJU_OP_JALB  = 4'h9,
    BJU_OP_JALF  = 4'hA,
    BJU_OP_JALR  = 4'hB,
    BJU_OP_JALRP = 4'hC,
    BJU_OP_JR    = 4'hD,
    BJU_OP_JRP   = 4'hE,
    BJU_OP_LNK   = 4'hF
  } bju_op_t;

  typedef struct packed {
    logic        redirect;
    logic [31:0] next_pc;
    logic        wr_en;
    logic [5:0]  wr_reg;
    logic [31:0] wr_data;
    logic        hint_valid;
    logic        hint_ok;
    logic        ind_valid;
    logic        ind_ok;
    logic        illegal;
    logic        done;
  } bju_state_t;
endpackage

// [hw/bju_ras.sv]
`timescale 1ns/1ps
`include "bju_defines.svh"

// Return-address stack; a pop and a push in one cycle swap the top entry
module bju_ras
  import bju_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Stack operations
  input  wire logic        push,
  input  wire logic [31:0] push_addr,
  input  wire logic        pop,
  output logic      [31:0] top_addr
);

  typedef struct packed {
    logic [`BJU_RAS_DEPTH-1:0][31:0] mem;
    logic [`BJU_RAS_PTR_W-1:0]       sp;
    logic [31:0]                     top;
  } bju_ras_t;

  bju_ras_t st_r;
  bju_ras_t st_nxt;
  logic [`BJU_RAS_PTR_W-1:0] sp_pop;

  // Top is kept in its own register, so the compare sees no mux after the array
  assign top_addr = st_r.top;

  always_comb begin
    st_nxt = st_r;
    sp_pop = pop ? st_r.sp - `BJU_RAS_PTR_W'(1) : st_r.sp;
    st_nxt.sp = sp_pop;
    // Overflow wraps and overwrites the oldest entry, never stalls
    if (push) begin
      st_nxt.mem[sp_pop] = push_addr;
      st_nxt.sp = sp_pop + `BJU_RAS_PTR_W'(1);
    end
    st_nxt.top = st_nxt.mem[st_nxt.sp - `BJU_RAS_PTR_W'(1)];
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule // bju_ras

// [hw/bju_unit.sv]
`timescale 1ns/1ps
`include "bju_defines.svh"

// Function
// [RULE1] Negative branch, not-taken hint
// [RULE2] Negative branch, taken hint
// [RULE3] Nonzero branch, not-taken hint
// [RULE4] Nonzero branch, taken hint
// [RULE5] Zero branch, not-taken hint
// [RULE6] Zero branch, taken hint
// [RULE7] Fail falls through; hint correctness reported
// [RULE8] Branches copy source to zero register
// [RULE9] Direct link jumps write return address
// [RULE10] Link jumps push return stack
// [RULE11] Backward jump adds bias plus scaled offset
// [RULE12] Forward jump adds scaled offset
// [RULE13] Backward jump opcode 0xA, bit 27
// [RULE14] Indirect link jump, push, hinted incorrect
// [RULE15] Predicted link jump pops, pushes, compares
// [RULE16] Plain indirect jump, hinted incorrect
// [RULE17] Predicted indirect jump pops and compares
// [RULE18] Link capture writes next address only
// [RULE19] Branch target uses scaled 17-bit offset
// [RULE20] Accepted only in slot one
module bju_unit
  import bju_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Issue
  input  wire logic        issue_valid,
  input  wire logic [1:0]  issue_slot,
  input  wire logic [63:0] insn,
  input  wire logic [31:0] cur_pc,
  input  wire logic [31:0] first_source_operand,
  // Fetch redirect
  output logic             redirect,
  output logic      [31:0] next_pc,
  // Register write-back
  output logic             wr_en,
  output logic      [5:0]  wr_reg,
  output logic      [31:0] wr_data,
  // Prediction reports
  output logic             hint_valid,
  output logic             hint_ok,
  output logic             ind_valid,
  output logic             ind_ok,
  // Decode status
  output logic             illegal,
  output logic             done
);

  localparam logic [1:0] SLOT_ONE = `BJU_SLOT_ONE;

  bju_state_t st_r;
  bju_state_t st_nxt;
  bju_op_t    op;
  logic [3:0]  opc;
  logic [3:0]  sub;
  logic [31:0] seq_pc;
  logic [31:0] br_tgt;
  logic [31:0] jf_tgt;
  logic [31:0] jb_tgt;
  logic [31:0] ind_tgt;
  logic        cond;
  logic        taken_hint;
  logic        is_branch;
  logic        ras_push;
  logic        ras_pop;
  logic [31:0] ras_top;
  logic        in_slot;
  logic [31:0] boff_ext;
  logic [31:0] jump_offset_field_ext;
  logic [5:0]  dst_fld;

  assign opc     = insn[`BJU_OPC_HI:`BJU_OPC_LO];
  assign sub     = insn[`BJU_SUB_HI:`BJU_SUB_LO];
  assign in_slot = issue_slot == SLOT_ONE;
  assign seq_pc  = cur_pc + `BJU_INSN_BYTES;

  // Raw fields for the checks, rebuilt apart from the target adders
  assign boff_ext = {{15{insn[`BJU_BOFF_HI]}}, insn[`BJU_BOFF_HI:`BJU_BOFF_LO]};
  assign jump_offset_field_ext = {4'h0, insn[`BJU_JUMP_OFFSET_FIELD_HI:`BJU_JUMP_OFFSET_FIELD_LO]};
  assign dst_fld  = insn[`BJU_DST_HI:`BJU_DST_LO];

  //--------------------------------------------------------------
  // Decode
  //--------------------------------------------------------------
  always_comb begin
    op = BJU_OP_NONE;
    case (opc)
      // [RULE13] backward jump opcode
      `BJU_OPC_JUMP_BACK: op = BJU_OP_JB;
      `BJU_OPC_JUMP_FWD:  op = BJU_OP_JF;
      `BJU_OPC_BRANCH: begin
        case (sub)
          `BJU_SUB_BLZ:  op = BJU_OP_BLZ;
          `BJU_SUB_BLZT: op = BJU_OP_BLZT;
          `BJU_SUB_BNZ:  op = BJU_OP_BNZ;
          `BJU_SUB_BNZT: op = BJU_OP_BNZT;
          `BJU_SUB_BZ:   op = BJU_OP_BZ;
          `BJU_SUB_BZT:  op = BJU_OP_BZT;
          default:       op = BJU_OP_NONE;
        endcase
      end
      `BJU_OPC_INDIRECT: begin
        case (sub)
          `BJU_SUB_JALR:  op = BJU_OP_JALR;
          `BJU_SUB_JALRP: op = BJU_OP_JALRP;
          `BJU_SUB_JR:    op = BJU_OP_JR;
          `BJU_SUB_JRP:   op = BJU_OP_JRP;
          `BJU_SUB_LNK:   op = BJU_OP_LNK;
          `BJU_SUB_JALB:  op = BJU_OP_JALB;
          `BJU_SUB_JALF:  op = BJU_OP_JALF;
          default:        op = BJU_OP_NONE;
        endcase
      end
      default: op = BJU_OP_NONE;
    endcase
  end

  //--------------------------------------------------------------
  // Targets
  //--------------------------------------------------------------
  // [RULE19] sign-extended scaled offset
  assign br_tgt = cur_pc + (32'(signed'(insn[`BJU_BOFF_HI:`BJU_BOFF_LO]))
                  << `BJU_INSN_SHIFT);
  // [RULE12] forward jump target
  assign jf_tgt = cur_pc + (32'(insn[`BJU_JUMP_OFFSET_FIELD_HI:`BJU_JUMP_OFFSET_FIELD_LO]) << `BJU_INSN_SHIFT);
  // [RULE11] backward jump target
  assign jb_tgt = cur_pc + `BJU_BACK_BIAS
                  + (32'(insn[`BJU_JUMP_OFFSET_FIELD_HI:`BJU_JUMP_OFFSET_FIELD_LO]) << `BJU_INSN_SHIFT);
  assign ind_tgt = first_source_operand & `BJU_ALIGN_MASK;

  //--------------------------------------------------------------
  // Branch condition
  //--------------------------------------------------------------
  always_comb begin
    cond       = 1'b0;
    taken_hint = 1'b0;
    is_branch  = 1'b1;
    case (op)
      // [RULE1] signed below zero
      BJU_OP_BLZ:  cond = first_source_operand[31];
      // [RULE2] same test, taken hint
      BJU_OP_BLZT: begin
        cond = first_source_operand[31];
        taken_hint = 1'b1;
      end
      // [RULE3] nonzero test
      BJU_OP_BNZ:  cond = |first_source_operand;
      // [RULE4] nonzero, taken hint
      BJU_OP_BNZT: begin
        cond = |first_source_operand;
        taken_hint = 1'b1;
      end
      // [RULE5] zero test
      BJU_OP_BZ:   cond = ~|first_source_operand;
      // [RULE6] zero, taken hint
      BJU_OP_BZT:  begin
        cond = ~|first_source_operand;
        taken_hint = 1'b1;
      end
      default: is_branch = 1'b0;
    endcase
  end

  //--------------------------------------------------------------
  // Return stack
  //--------------------------------------------------------------
  logic go;
  assign go = issue_valid && in_slot;
  // [RULE10] link jumps push
  assign ras_push = go && (op == BJU_OP_JALB || op == BJU_OP_JALF
                    || op == BJU_OP_JALR || op == BJU_OP_JALRP);
  // [RULE15] pop before push on the predicted forms
  assign ras_pop  = go && (op == BJU_OP_JALRP || op == BJU_OP_JRP);

  bju_ras u_ras (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .push      (ras_push),
    .push_addr (seq_pc),
    .pop       (ras_pop),
    .top_addr  (ras_top)
  );

  //--------------------------------------------------------------
  // Result
  //--------------------------------------------------------------
  always_comb begin
    st_nxt = '0;
    st_nxt.done = issue_valid;
    // [RULE20] other slots are illegal
    if (issue_valid && !in_slot && op != BJU_OP_NONE) begin
      st_nxt.illegal = 1'b1;
    end else if (go) begin
      if (is_branch) begin
        // [RULE7] taken target or fall-through, hint report
        st_nxt.redirect   = 1'b1;
        st_nxt.next_pc    = cond ? br_tgt : seq_pc;
        st_nxt.hint_valid = 1'b1;
        st_nxt.hint_ok    = cond == taken_hint;
        // [RULE8] source copied to zero register
        st_nxt.wr_en   = 1'b1;
        st_nxt.wr_reg  = `BJU_ZERO_REG;
        st_nxt.wr_data = first_source_operand;
      end
      case (op)
        BJU_OP_JB, BJU_OP_JALB: begin
          st_nxt.redirect = 1'b1;
          st_nxt.next_pc  = jb_tgt;
        end
        BJU_OP_JF, BJU_OP_JALF: begin
          st_nxt.redirect = 1'b1;
          st_nxt.next_pc  = jf_tgt;
        end
        // [RULE14] [RULE16] indirect, hinted incorrect
        BJU_OP_JALR, BJU_OP_JR: begin
          st_nxt.redirect  = 1'b1;
          st_nxt.next_pc   = ind_tgt;
          st_nxt.ind_valid = 1'b1;
        end
        // [RULE15] [RULE17] compare popped address
        BJU_OP_JALRP, BJU_OP_JRP: begin
          st_nxt.redirect  = 1'b1;
          st_nxt.next_pc   = ind_tgt;
          st_nxt.ind_valid = 1'b1;
          st_nxt.ind_ok    = ras_top == ind_tgt;
        end
        // [RULE18] link capture to destination
        BJU_OP_LNK: begin
          st_nxt.wr_en   = 1'b1;
          st_nxt.wr_reg  = insn[`BJU_DST_HI:`BJU_DST_LO];
          st_nxt.wr_data = seq_pc;
        end
        default: ;
      endcase
      // [RULE9] link register write
      if (op == BJU_OP_JALB || op == BJU_OP_JALF || op == BJU_OP_JALR
          || op == BJU_OP_JALRP) begin
        st_nxt.wr_en   = 1'b1;
        st_nxt.wr_reg  = `BJU_LINK_REG;
        st_nxt.wr_data = seq_pc;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign redirect   = st_r.redirect;
  assign next_pc    = st_r.next_pc;
  assign wr_en      = st_r.wr_en;
  assign wr_reg     = st_r.wr_reg;
  assign wr_data    = st_r.wr_data;
  assign hint_valid = st_r.hint_valid;
  assign hint_ok    = st_r.hint_ok;
  assign ind_valid  = st_r.ind_valid;
  assign ind_ok     = st_r.ind_ok;
  assign illegal    = st_r.illegal;
  assign done       = st_r.done;

  //--------------------------------------------------------------
  // Checks
  //--------------------------------------------------------------
  AST_BLZ_TAKEN: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE1]
    go && op == BJU_OP_BLZ && $signed(first_source_operand) < 0
    |=> next_pc == $past(br_tgt) && !hint_ok) else $error("blz target wrong");
  AST_BLZT_HINT: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE2]
    go && op == BJU_OP_BLZT |=> hint_ok == $past(first_source_operand[31]))
    else $error("blzt hint wrong");
  AST_BNZ_TAKEN: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE3]
    go && op == BJU_OP_BNZ && first_source_operand != 32'h0000_0000
    |=> next_pc == $past(br_tgt)) else $error("bnz target wrong");
  AST_BZ_FALL: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE7]
    go && op == BJU_OP_BZ && first_source_operand != 32'h0000_0000
    |=> next_pc == $past(seq_pc) && hint_ok) else $error("bz fallthrough wrong");
  AST_ZERO_COPY: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE8]
    go && is_branch |=> wr_en && wr_reg == `BJU_ZERO_REG
    && wr_data == $past(first_source_operand)) else $error("zero copy missing");
  AST_LINK_WR: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE9]
    go && (op == BJU_OP_JALF || op == BJU_OP_JALB)
    |=> wr_reg == `BJU_LINK_REG && wr_data == $past(cur_pc) + `BJU_INSN_BYTES)
    else $error("link write wrong");
  AST_JR_IND: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE16]
    go && op == BJU_OP_JR |=> ind_valid && !ind_ok && !wr_en
    && next_pc[2:0] == 3'h0) else $error("jr report wrong");
  AST_JALRP_CMP: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE15]
    go && op == BJU_OP_JALRP |=> ind_ok == ($past(ras_top) == $past(ind_tgt)))
    else $error("jalrp compare wrong");
  AST_SLOT: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE20]
    issue_valid && !in_slot && op != BJU_OP_NONE |=> illegal && !redirect)
    else $error("wrong slot accepted");
  AST_BNZT_HINT: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE4]
    go && op == BJU_OP_BNZT
    |=> redirect && hint_ok == ($past(first_source_operand) != 32'h0000_0000))
    else $error("bnzt hint wrong");
  AST_BZ_TAKEN: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE5]
    go && op == BJU_OP_BZ && first_source_operand == 32'h0000_0000
    |=> next_pc == $past(br_tgt) && !hint_ok) else $error("bz target wrong");
  AST_BZT_HINT: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE6]
    go && op == BJU_OP_BZT
    |=> redirect && hint_ok == ($past(first_source_operand) == 32'h0000_0000))
    else $error("bzt hint wrong");
  AST_RAS_PUSH: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE10]
    go && (op == BJU_OP_JALB || op == BJU_OP_JALF || op == BJU_OP_JALR
    || op == BJU_OP_JALRP) |=> ras_top == $past(cur_pc) + `BJU_INSN_BYTES)
    else $error("return address not pushed");
  AST_JB_TGT: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE11]
    go && op == BJU_OP_JB |=> redirect && next_pc == $past(cur_pc) + `BJU_BACK_BIAS
    + ($past(jump_offset_field_ext) << `BJU_INSN_SHIFT)) else $error("jb target wrong");
  AST_JF_TGT: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE12]
    go && op == BJU_OP_JF
    |=> redirect && next_pc == $past(cur_pc) + ($past(jump_offset_field_ext) << `BJU_INSN_SHIFT))
    else $error("jf target wrong");
  AST_JB_OPC: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE13]
    go && opc == `BJU_OPC_JUMP_BACK |=> redirect && !wr_en && !hint_valid && !ind_valid)
    else $error("jb decode wrong");
  AST_JALR_IND: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE14]
    go && op == BJU_OP_JALR |=> ind_valid && !ind_ok && wr_en && wr_reg == `BJU_LINK_REG
    && next_pc == ($past(first_source_operand) & `BJU_ALIGN_MASK))
    else $error("jalr report wrong");
  AST_JRP_CMP: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE17]
    go && op == BJU_OP_JRP |=> ind_valid && !wr_en
    && ind_ok == ($past(ras_top) == ($past(first_source_operand) & `BJU_ALIGN_MASK)))
    else $error("jrp compare wrong");
  AST_LNK_WR: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE18]
    go && op == BJU_OP_LNK |=> wr_en && !redirect && wr_reg == $past(dst_fld)
    && wr_data == $past(cur_pc) + `BJU_INSN_BYTES && ras_top == $past(ras_top))
    else $error("lnk write wrong");
  AST_BR_TGT: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE19]
    go && is_branch && cond
    |=> next_pc == $past(cur_pc) + ($past(boff_ext) << `BJU_INSN_SHIFT))
    else $error("branch target wrong");

  COV_BRANCH: cover property (@(posedge mclk) disable iff (!rst_n)
    go && is_branch && cond);
  COV_RET_HIT: cover property (@(posedge mclk) disable iff (!rst_n)
    go && op == BJU_OP_JRP && ras_top == ind_tgt);
  COV_CALL_RET: cover property (@(posedge mclk) disable iff (!rst_n)
    (go && op == BJU_OP_JALF) ##[1:4] (go && op == BJU_OP_JRP));
  COV_FALL_THROUGH: cover property (@(posedge mclk) disable iff (!rst_n)
    go && is_branch && !cond);

endmodule // bju_unit

// [test/tb.sv]
`timescale 1ns/1ps
`include "bju_defines.svh"

module tb
  import bju_pkg::*;
;
  logic        mclk, rst_n, issue_valid, redirect, wr_en, hint_valid, hint_ok;
  logic        ind_valid, ind_ok, illegal, done;
  logic [1:0]  issue_slot;
  logic [63:0] insn;
  logic [31:0] cur_pc, first_source_operand, next_pc, wr_data;
  logic [5:0]  wr_reg;
  int          n_mismatch = 0;
  int          checks_done = 0;

  bju_unit dut_u (
    .mclk, .rst_n, .issue_valid, .issue_slot, .insn, .cur_pc, .first_source_operand,
    .redirect, .next_pc, .wr_en, .wr_reg, .wr_data, .hint_valid, .hint_ok,
    .ind_valid, .ind_ok, .illegal, .done
  );

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic cmp_bit(input string nm, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %b seen %b", nm, exp, got);
    end
  endtask

  task automatic cmp_word(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Field f fills bits 58:31, so sub-op and offsets land in place
  function automatic logic [63:0] mk(input logic [3:0] opc, input logic [27:0] f);
    return {1'b0, opc, f, 31'h0};
  endfunction

  function automatic logic [63:0] ind(input logic [3:0] sub, input logic [5:0] dst);
    return mk(`BJU_OPC_INDIRECT, {7'h0, sub, 11'h0, dst});
  endfunction

  // One issue, then sample just after the answering edge
  task automatic issue(input logic [1:0] slot, input logic [63:0] word,
                       input logic [31:0] pc, input logic [31:0] src);
    @(posedge mclk);
    issue_valid          <= 1'b1;
    issue_slot           <= slot;
    insn                 <= word;
    cur_pc               <= pc;
    first_source_operand <= src;
    @(posedge mclk);
    issue_valid <= 1'b0;
    #1;
  endtask

  task automatic expect_out(input logic red, input logic [31:0] npc, input logic we,
                            input logic [5:0] wreg, input logic [31:0] wdat, input logic hv,
                            input logic hok, input logic iv, input logic iok, input logic ill);
    cmp_bit("redirect", red, redirect);
    if (red) cmp_word("next_pc", npc, next_pc);
    cmp_bit("wr_en", we, wr_en);
    if (we) cmp_word("wr_reg", {26'h0, wreg}, {26'h0, wr_reg});
    if (we) cmp_word("wr_data", wdat, wr_data);
    cmp_bit("hint_valid", hv, hint_valid);
    if (hv) cmp_bit("hint_ok", hok, hint_ok);
    cmp_bit("ind_valid", iv, ind_valid);
    if (iv) cmp_bit("ind_ok", iok, ind_ok);
    cmp_bit("illegal", ill, illegal);
    cmp_bit("done", 1'b1, done);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_branch();
    logic [31:0] srcs [4] = '{32'h0, 32'h1, 32'h8000_0000, 32'hFFFF_FFFF};
    logic [16:0] offs [4] = '{17'h1_0000, 17'h0_FFFF, 17'h0_0001, 17'h1_FFFF};
    logic        tk;
    logic [31:0] pc;
    logic [31:0] nxt;
    for (int s = 0; s < 6; s++) begin
      for (int v = 0; v < 4; v++) begin
        pc = 32'h0001_0000 + 32'(v * 16);
        case (s / 2)
          0: tk = $signed(srcs[v]) < 0;
          1: tk = srcs[v] != 32'h0;
          default: tk = srcs[v] == 32'h0;
        endcase
        nxt = pc + `BJU_INSN_BYTES;
        if (tk) nxt = pc + ({{15{offs[v][16]}}, offs[v]} << `BJU_INSN_SHIFT);
        issue(2'h1, mk(`BJU_OPC_BRANCH, {7'h0, 4'(s), offs[v]}), pc, srcs[v]);
        expect_out('1, nxt, '1, `BJU_ZERO_REG, srcs[v], '1, tk == s[0], '0, '0, '0);
      end
    end
  endtask

  task automatic t_direct();
    issue(2'h1, mk(`BJU_OPC_JUMP_BACK, 28'h800_0010), 32'h2000, 32'h0);
    expect_out('1, 32'h2000 + `BJU_BACK_BIAS + 32'h4000_0080, '0, '0, '0, '0, '0, '0, '0, '0);
    issue(2'h1, mk(`BJU_OPC_JUMP_FWD, 28'h000_0020), 32'h2100, 32'h0);
    expect_out('1, 32'h2200, '0, '0, '0, '0, '0, '0, '0, '0);
    issue(2'h1, mk(`BJU_OPC_INDIRECT, 28'h80A_0001), 32'h2200, 32'h0);
    expect_out('1, 32'h2200 + `BJU_BACK_BIAS + 32'h4050_0008, '1, `BJU_LINK_REG, 32'h2208,
               '0, '0, '0, '0, '0);
    issue(2'h1, mk(`BJU_OPC_INDIRECT, 28'h00C_0004), 32'h2300, 32'h0);
    expect_out('1, 32'h0060_2320, '1, `BJU_LINK_REG, 32'h2308, '0, '0, '0, '0, '0);
    issue(2'h1, ind(`BJU_SUB_JRP, 6'h0), 32'h2400, 32'h2308);
    expect_out('1, 32'h2308, '0, '0, '0, '0, '0, '1, '1, '0);
    issue(2'h1, ind(`BJU_SUB_JRP, 6'h0), 32'h2500, 32'h2208);
    expect_out('1, 32'h2208, '0, '0, '0, '0, '0, '1, '1, '0);
  endtask

  task automatic t_indirect();
    issue(2'h1, ind(`BJU_SUB_JALR, 6'h0), 32'h3000, 32'h5007);
    expect_out('1, 32'h5000, '1, `BJU_LINK_REG, 32'h3008, '0, '0, '1, '0, '0);
    issue(2'h1, ind(`BJU_SUB_JALR, 6'h0), 32'h3040, 32'h5007);
    expect_out('1, 32'h5000, '1, `BJU_LINK_REG, 32'h3048, '0, '0, '1, '0, '0);
    issue(2'h1, ind(`BJU_SUB_LNK, 6'h05), 32'h3100, 32'h0);
    expect_out('0, '0, '1, 6'h05, 32'h3108, '0, '0, '0, '0, '0);
    issue(2'h1, ind(`BJU_SUB_JR, 6'h0), 32'h3200, 32'h6003);
    expect_out('1, 32'h6000, '0, '0, '0, '0, '0, '1, '0, '0);
    // Stack top must still be the second link push
    issue(2'h1, ind(`BJU_SUB_JRP, 6'h0), 32'h3300, 32'h304F);
    expect_out('1, 32'h3048, '0, '0, '0, '0, '0, '1, '1, '0);
    issue(2'h1, ind(`BJU_SUB_JALRP, 6'h0), 32'h3500, 32'h9004);
    expect_out('1, 32'h9000, '1, `BJU_LINK_REG, 32'h3508, '0, '0, '1, '0, '0);
    issue(2'h1, ind(`BJU_SUB_JALRP, 6'h0), 32'h3600, 32'h3508);
    expect_out('1, 32'h3508, '1, `BJU_LINK_REG, 32'h3608, '0, '0, '1, '1, '0);
    issue(2'h1, ind(`BJU_SUB_JRP, 6'h0), 32'h3700, 32'h3010);
    expect_out('1, 32'h3010, '0, '0, '0, '0, '0, '1, '0, '0);
  endtask

  task automatic t_illegal();
    logic [1:0] sl [3] = '{2'h0, 2'h2, 2'h3};
    for (int i = 0; i < 3; i++) begin
      issue(sl[i], ind(`BJU_SUB_JALR, 6'h0), 32'h4000, 32'h4100);
      expect_out('0, '0, '0, '0, '0, '0, '0, '0, '0, '1);
      issue(sl[i], mk(`BJU_OPC_BRANCH, 28'h0), 32'h4000, 32'h0);
      expect_out('0, '0, '0, '0, '0, '0, '0, '0, '0, '1);
    end
    issue(2'h1, ind(`BJU_SUB_JALR, 6'h0), 32'h4200, 32'h4100);
    expect_out('1, 32'h4100, '1, `BJU_LINK_REG, 32'h4208, '0, '0, '1, '0, '0);
    issue(2'h0, ind(`BJU_SUB_JRP, 6'h0), 32'h4300, 32'h4208);
    expect_out('0, '0, '0, '0, '0, '0, '0, '0, '0, '1);
    issue(2'h1, ind(`BJU_SUB_JRP, 6'h0), 32'h4400, 32'h4208);
    expect_out('1, 32'h4208, '0, '0, '0, '0, '0, '1, '1, '0);
    // Undefined opcode gives only the completion pulse
    issue(2'h1, mk(4'h3, 28'h0), 32'h4500, 32'h0);
    expect_out('0, '0, '0, '0, '0, '0, '0, '0, '0, '0);
    @(posedge mclk);
    #1;
    cmp_bit("done", 1'b0, done);
    cmp_bit("redirect", 1'b0, redirect);
  endtask

  task automatic wrap_up();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Backstop against a stalled run
  initial begin
    repeat (3000) @(posedge mclk);
    n_mismatch++;
    wrap_up();
  end

  initial begin
    rst_n                = 1'b0;
    issue_valid          = 1'b0;
    issue_slot           = 2'h0;
    insn                 = 64'h0;
    cur_pc               = 32'h0;
    first_source_operand = 32'h0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    #1;
    cmp_bit("done", 1'b0, done);
    cmp_bit("redirect", 1'b0, redirect);
    t_branch();
    t_direct();
    t_indirect();
    t_illegal();
    wrap_up();
  end
endmodule // tb
